// ---- npt_fe_model.sv ----
// Purpose: front-end clock model for the protocol timer unit
// Assumes: one carrier tick per cycle while the crystal runs
// Notes:   the rc oscillator stands still until it is enabled
module npt_fe_model #(
  parameter int RC_DIV = 8
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // oscillator controls
  input  wire logic osc_ok_i,
  input  wire logic rc_en_i,
  // ticks
  output logic      fc_tick_o,
  output logic      rc_tick_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rc_cnt_ff;
  logic [7:0] nxt_rc_cnt;
  logic       rc_wrap;

  // no carrier while the crystal is stopped
  assign fc_tick_o = osc_ok_i;
  assign rc_wrap   = rc_cnt_ff == 8'(RC_DIV - 1);
  assign rc_tick_o = rc_en_i && rc_wrap;

  always_comb begin
    nxt_rc_cnt = rc_cnt_ff + 8'h01;
    if (!rc_en_i || rc_wrap) begin
      nxt_rc_cnt = 8'h00;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rc_cnt_ff <= 8'h00;
    end else begin
      rc_cnt_ff <= nxt_rc_cnt;
    end
  end
endmodule // npt_fe_model

// ---- npt_pkg.sv ----
// Purpose: shared constants for the protocol timer unit
// Assumes: classic Wishbone slave, word-indexed registers
// Notes:   byte address of a register is four times its index
package npt_pkg;

  // ----------------------------------------------------------
  // register indices
  // ----------------------------------------------------------
  localparam logic [5:0] REG_CTRL = 6'h00;
  localparam logic [5:0] REG_NRT  = 6'h01;
  localparam logic [5:0] REG_GP   = 6'h02;
  localparam logic [5:0] REG_PPON = 6'h03;
  localparam logic [5:0] REG_WU   = 6'h04;
  localparam logic [5:0] REG_CMD  = 6'h05;
  localparam logic [5:0] REG_TIRQ = 6'h06;
  localparam logic [5:0] REG_EIRQ = 6'h07;
  localparam logic [5:0] REG_STAT = 6'h08;

  // ----------------------------------------------------------
  // control fields, command bits, flag bits
  // ----------------------------------------------------------
  localparam int CTL_STEP   = 0;
  localparam int CTL_UNCOND = 1;
  localparam int CTL_PEER   = 2;
  localparam int CTL_GPT_LO = 3;
  localparam int CTL_GPT_HI = 4;
  localparam int CTL_MOD_LO = 5;
  localparam int CTL_MOD_HI = 7;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [15:0] LIM_RST = 16'hFFFF;

  localparam int CMD_NRT_GO   = 0;
  localparam int CMD_NRT_STOP = 1;
  localparam int CMD_GP_GO    = 2;
  localparam int CMD_WU_GO    = 3;
  localparam int CMD_STOP_ALL = 4;
  localparam int CMD_W        = 5;

  localparam int TIRQ_NRT  = 0;
  localparam int TIRQ_GP   = 1;
  localparam int TIRQ_PPON = 2;
  localparam int TIRQ_W    = 3;

  // ----------------------------------------------------------
  // step prescaler: 64 and 4096 carrier periods
  // ----------------------------------------------------------
  localparam int PRE_W = 12;
  localparam logic [5:0]  PRE_FINE_MAX   = 6'h3F;
  localparam logic [11:0] PRE_COARSE_MAX = 12'hFFF;

  typedef enum logic [2:0] {
    MODE_READER   = 3'h0,
    MODE_ACT_INIT = 3'h1,
    MODE_ACT_TGT  = 3'h2,
    MODE_BITRATE  = 3'h3,
    MODE_PAS_TGT  = 3'h4,
    MODE_WAKEUP   = 3'h5
  } npt_mode_t;

  typedef enum logic [1:0] {
    GPT_CMD   = 2'h0,
    GPT_RXS   = 2'h1,
    GPT_RXE   = 2'h2,
    GPT_TXOFF = 2'h3
  } npt_gpt_t;

endpackage

// ---- npt_presc.sv ----
// Purpose: carrier step prescaler for the crystal timers
// Assumes: fc_tick_i is a one-cycle pulse per carrier period
// Notes:   free running, so a start may lose up to one step
module npt_presc (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // carrier
  input  wire logic fc_tick_i,
  input  wire logic run_i,
  // steps
  output logic      fine_o,
  output logic      coarse_o
);

  logic [npt_pkg::PRE_W-1:0] cnt_ff;
  logic [npt_pkg::PRE_W-1:0] nxt_cnt;
  logic                      adv;

  assign adv = fc_tick_i & run_i;
  assign fine_o = adv & (cnt_ff[5:0] == npt_pkg::PRE_FINE_MAX);
  assign coarse_o = adv & (cnt_ff == npt_pkg::PRE_COARSE_MAX);

  always_comb begin
    nxt_cnt = cnt_ff;
    if (adv) begin
      nxt_cnt = cnt_ff + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

endmodule // npt_presc

// ---- npt_timer.sv ----
// Purpose: one restartable step timer
// Assumes: start has priority over stop, stop over a step
// Notes:   expires after max(limit,1) steps, then idles
module npt_timer #(
  parameter int W = 16
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // control
  input  wire logic         start_i,
  input  wire logic         stop_i,
  input  wire logic         tick_i,
  input  wire logic [W-1:0] limit_i,
  // state
  output logic              running_o,
  output logic              expire_o
);

  typedef enum logic {TM_IDLE = 1'b0, TM_RUN = 1'b1} npt_tm_st_t;

  npt_tm_st_t     st_ff;
  npt_tm_st_t     nxt_st;
  logic [W-1:0]   cnt_ff;
  logic [W-1:0]   nxt_cnt;
  logic           exp_ff;
  logic           nxt_exp;

  always_comb begin
    nxt_st = st_ff;
    nxt_cnt = cnt_ff;
    nxt_exp = 1'b0;
    if (start_i) begin
      nxt_st = TM_RUN;
      nxt_cnt = '0;
    end else if (stop_i) begin
      nxt_st = TM_IDLE;
    end else if (st_ff == TM_RUN && tick_i) begin
      nxt_cnt = cnt_ff + 1'b1;
      if (nxt_cnt >= limit_i) begin
        nxt_st = TM_IDLE;
        nxt_exp = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff <= TM_IDLE;
      cnt_ff <= '0;
      exp_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      exp_ff <= nxt_exp;
    end
  end

  assign running_o = (st_ff == TM_RUN);
  assign expire_o = exp_ff;

endmodule // npt_timer

// ---- npt_top.sv ----
// Purpose: protocol timer unit with Wishbone register access
// Assumes: front-end events are one-cycle pulses on clk_i
// Notes:   flag registers clear on read; set wins over clear
module npt_top #(
  parameter int NRT_W = 16,
  parameter int GP_W  = 16,
  parameter int PP_W  = 16,
  parameter int WU_W  = 16
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:2]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // front-end events
  input  wire logic        tx_end_i,
  input  wire logic        tx_field_off_i,
  input  wire logic        peer_field_on_i,
  input  wire logic        rx_start_i,
  input  wire logic        rx_end_i,
  input  wire logic        rx_busy_i,
  // clocks of the timers
  input  wire logic        fc_tick_i,
  input  wire logic        osc_ok_i,
  input  wire logic        rc_tick_i,
  // outputs
  output logic             rx_gate_o,
  output logic             rc_osc_en_o,
  output logic             irq_o
);

  // ----------------------------------------------------------
  // register file
  // ----------------------------------------------------------
  logic [7:0]              ctrl_ff;
  logic [7:0]              nxt_ctrl;
  logic [15:0]             nrt_lim_ff;
  logic [15:0]             nxt_nrt_lim;
  logic [15:0]             gp_lim_ff;
  logic [15:0]             nxt_gp_lim;
  logic [15:0]             pp_lim_ff;
  logic [15:0]             nxt_pp_lim;
  logic [15:0]             wu_lim_ff;
  logic [15:0]             nxt_wu_lim;
  logic [npt_pkg::CMD_W-1:0] cmd_ff;
  logic [npt_pkg::CMD_W-1:0] nxt_cmd;
  logic                    ack_ff;
  logic                    nxt_ack;
  logic [31:0]             rdat_ff;
  logic [31:0]             nxt_rdat;
  logic [31:0]             rmux;
  logic                    acc;
  logic                    wr;
  logic                    rd;

  // timer flags and status
  logic [npt_pkg::TIRQ_W-1:0] tirq_ff;
  logic [npt_pkg::TIRQ_W-1:0] nxt_tirq;
  logic [npt_pkg::TIRQ_W-1:0] tirq_set;
  logic                    wt_ff;
  logic                    nxt_wt;
  logic                    gate_ff;
  logic                    nxt_gate;
  logic                    clr_tirq;
  logic                    clr_eirq;

  // decoded control
  npt_pkg::npt_mode_t      mode;
  npt_pkg::npt_gpt_t       gpt;
  logic                    uncond;
  logic                    peer_start;
  logic                    active;
  logic                    stop_all;

  // timer hookups
  logic                    step_fine;
  logic                    step_coarse;
  logic                    nrt_tick;
  logic                    nrt_go;
  logic                    nrt_auto;
  logic                    nrt_halt;
  logic                    nrt_run;
  logic                    nrt_exp;
  logic                    gp_go;
  logic                    gp_run;
  logic                    gp_exp;
  logic                    pp_run;
  logic                    pp_exp;
  logic                    wu_go;
  logic                    wu_run;
  logic                    wu_exp;

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] dat,
                                          input logic [3:0]  sel);
    logic [15:0] res;
    res = old;
    if (sel[0]) res[7:0] = dat[7:0];
    if (sel[1]) res[15:8] = dat[15:8];
    return res;
  endfunction

  assign acc = wb_cyc_i & wb_stb_i & ~ack_ff;
  assign wr = acc & wb_we_i;
  assign rd = acc & ~wb_we_i;
  assign clr_tirq = rd & (wb_adr_i == npt_pkg::REG_TIRQ);
  assign clr_eirq = rd & (wb_adr_i == npt_pkg::REG_EIRQ);

  always_comb begin
    rmux = '0;
    unique case (wb_adr_i)
      npt_pkg::REG_CTRL: rmux[7:0] = ctrl_ff;
      npt_pkg::REG_NRT:  rmux[15:0] = nrt_lim_ff;
      npt_pkg::REG_GP:   rmux[15:0] = gp_lim_ff;
      npt_pkg::REG_PPON: rmux[15:0] = pp_lim_ff;
      npt_pkg::REG_WU:   rmux[15:0] = wu_lim_ff;
      npt_pkg::REG_TIRQ: rmux[npt_pkg::TIRQ_W-1:0] = tirq_ff;
      npt_pkg::REG_EIRQ: rmux[0] = wt_ff;
      npt_pkg::REG_STAT: rmux[5:0] = {osc_ok_i, gate_ff, wu_run,
                                      pp_run, gp_run, nrt_run};
      default:           rmux = '0;
    endcase
  end

  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_nrt_lim = nrt_lim_ff;
    nxt_gp_lim = gp_lim_ff;
    nxt_pp_lim = pp_lim_ff;
    nxt_wu_lim = wu_lim_ff;
    nxt_cmd = '0;
    nxt_ack = acc;
    nxt_rdat = rdat_ff;
    if (wr) begin
      unique case (wb_adr_i)
        npt_pkg::REG_CTRL: if (wb_sel_i[0]) nxt_ctrl = wb_dat_i[7:0];
        npt_pkg::REG_NRT:  nxt_nrt_lim = merge16(nrt_lim_ff, wb_dat_i,
                                                 wb_sel_i);
        npt_pkg::REG_GP:   nxt_gp_lim = merge16(gp_lim_ff, wb_dat_i,
                                                wb_sel_i);
        npt_pkg::REG_PPON: nxt_pp_lim = merge16(pp_lim_ff, wb_dat_i,
                                                wb_sel_i);
        npt_pkg::REG_WU:   nxt_wu_lim = merge16(wu_lim_ff, wb_dat_i,
                                                wb_sel_i);
        npt_pkg::REG_CMD:  if (wb_sel_i[0]) begin
          nxt_cmd = wb_dat_i[npt_pkg::CMD_W-1:0];
        end
        default:           nxt_cmd = '0;
      endcase
    end
    if (rd) begin
      nxt_rdat = rmux;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_ff <= npt_pkg::CTRL_RST;
      nrt_lim_ff <= npt_pkg::LIM_RST;
      gp_lim_ff <= npt_pkg::LIM_RST;
      pp_lim_ff <= npt_pkg::LIM_RST;
      wu_lim_ff <= npt_pkg::LIM_RST;
      cmd_ff <= '0;
      ack_ff <= 1'b0;
      rdat_ff <= '0;
    end else begin
      ctrl_ff <= nxt_ctrl;
      nrt_lim_ff <= nxt_nrt_lim;
      gp_lim_ff <= nxt_gp_lim;
      pp_lim_ff <= nxt_pp_lim;
      wu_lim_ff <= nxt_wu_lim;
      cmd_ff <= nxt_cmd;
      ack_ff <= nxt_ack;
      rdat_ff <= nxt_rdat;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;

  // ----------------------------------------------------------
  // decoded control
  // ----------------------------------------------------------
  assign mode = npt_pkg::npt_mode_t'(
                ctrl_ff[npt_pkg::CTL_MOD_HI:npt_pkg::CTL_MOD_LO]);
  assign gpt = npt_pkg::npt_gpt_t'(
               ctrl_ff[npt_pkg::CTL_GPT_HI:npt_pkg::CTL_GPT_LO]);
  assign uncond = ctrl_ff[npt_pkg::CTL_UNCOND];
  assign peer_start = ctrl_ff[npt_pkg::CTL_PEER];
  assign active = (mode == npt_pkg::MODE_ACT_INIT) ||
                  (mode == npt_pkg::MODE_ACT_TGT) ||
                  (mode == npt_pkg::MODE_BITRATE);
  assign stop_all = cmd_ff[npt_pkg::CMD_STOP_ALL];

  // ----------------------------------------------------------
  // no-response timer
  // ----------------------------------------------------------
  npt_presc u_presc (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .fc_tick_i (fc_tick_i),
    .run_i     (osc_ok_i),
    .fine_o    (step_fine),
    .coarse_o  (step_coarse)
  );

  assign nrt_tick = ctrl_ff[npt_pkg::CTL_STEP] ? step_coarse
                                               : step_fine;

  always_comb begin
    nrt_auto = 1'b0;
    unique case (mode)
      npt_pkg::MODE_READER:   nrt_auto = tx_end_i;
      npt_pkg::MODE_ACT_INIT,
      npt_pkg::MODE_ACT_TGT:  nrt_auto = peer_start ? peer_field_on_i
                                                    : tx_field_off_i;
      npt_pkg::MODE_BITRATE:  nrt_auto = ~peer_start &
                                         tx_field_off_i;
      npt_pkg::MODE_PAS_TGT:  nrt_auto = 1'b0;
      npt_pkg::MODE_WAKEUP:   nrt_auto = 1'b0;
      default:                nrt_auto = 1'b0;
    endcase
  end

  assign nrt_go = cmd_ff[npt_pkg::CMD_NRT_GO] | nrt_auto;
  assign nrt_halt = cmd_ff[npt_pkg::CMD_NRT_STOP] |
                    (stop_all & ~uncond) |
                    (rx_start_i & ~uncond);

  npt_timer #(.W(NRT_W)) u_nrt (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .start_i   (nrt_go),
    .stop_i    (nrt_halt),
    .tick_i    (nrt_tick),
    .limit_i   (nrt_lim_ff[NRT_W-1:0]),
    .running_o (nrt_run),
    .expire_o  (nrt_exp)
  );

  // receiver gate: reopened by a new start, closed on expiry unless uncond is set and rx_busy_i is high
  always_comb begin
    nxt_gate = gate_ff;
    if (nrt_go) begin
      nxt_gate = 1'b1;
    end else if (nrt_exp && (!uncond || !rx_busy_i)) begin
      nxt_gate = 1'b0;
    end
  end

  // ----------------------------------------------------------
  // general purpose, peer wait and wake timers
  // ----------------------------------------------------------
  always_comb begin
    gp_go = cmd_ff[npt_pkg::CMD_GP_GO];
    unique case (gpt)
      npt_pkg::GPT_CMD:   gp_go = cmd_ff[npt_pkg::CMD_GP_GO];
      npt_pkg::GPT_RXS:   gp_go = gp_go | rx_start_i;
      npt_pkg::GPT_RXE:   gp_go = gp_go | rx_end_i;
      npt_pkg::GPT_TXOFF: gp_go = gp_go | (active & tx_field_off_i);
    endcase
  end

  npt_timer #(.W(GP_W)) u_gp (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .start_i   (gp_go),
    .stop_i    (stop_all),
    .tick_i    (step_fine),
    .limit_i   (gp_lim_ff[GP_W-1:0]),
    .running_o (gp_run),
    .expire_o  (gp_exp)
  );

  npt_timer #(.W(PP_W)) u_pp (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .start_i   (active & tx_field_off_i),
    .stop_i    (stop_all | peer_field_on_i),
    .tick_i    (step_fine),
    .limit_i   (pp_lim_ff[PP_W-1:0]),
    .running_o (pp_run),
    .expire_o  (pp_exp)
  );

  assign wu_go = (cmd_ff[npt_pkg::CMD_WU_GO] &
                  (mode != npt_pkg::MODE_WAKEUP)) |
                 ((mode == npt_pkg::MODE_PAS_TGT) &
                  peer_field_on_i);

  npt_timer #(.W(WU_W)) u_wu (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .start_i   (wu_go),
    .stop_i    (stop_all),
    .tick_i    (rc_tick_i),
    .limit_i   (wu_lim_ff[WU_W-1:0]),
    .running_o (wu_run),
    .expire_o  (wu_exp)
  );

  assign rc_osc_en_o = wu_run;

  // ----------------------------------------------------------
  // flags
  // ----------------------------------------------------------
  always_comb begin
    tirq_set = '0;
    tirq_set[npt_pkg::TIRQ_NRT] = nrt_exp;
    tirq_set[npt_pkg::TIRQ_GP] = gp_exp;
    tirq_set[npt_pkg::TIRQ_PPON] = pp_exp;
    nxt_tirq = (tirq_ff & ~{npt_pkg::TIRQ_W{clr_tirq}}) | tirq_set;
    nxt_wt = (wt_ff & ~clr_eirq) | wu_exp;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tirq_ff <= '0;
      wt_ff <= 1'b0;
      gate_ff <= 1'b1;
    end else begin
      tirq_ff <= nxt_tirq;
      wt_ff <= nxt_wt;
      gate_ff <= nxt_gate;
    end
  end

  assign rx_gate_o = gate_ff;
  assign irq_o = (|tirq_ff) | wt_ff;

  // ----------------------------------------------------------
  // checks
  // ----------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  bus_answer_a: assert property (acc |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus access not answered in one cycle");
  nrt_auto_a: assert property (
    (mode == npt_pkg::MODE_READER && tx_end_i) |=> nrt_run)
    else $error("no-response timer not started at tx end");
  nrt_gate_a: assert property (
    (nrt_exp && !uncond && !nrt_go) |=>
      !rx_gate_o && tirq_ff[npt_pkg::TIRQ_NRT])
    else $error("default expiry did not flag and gate");
  nrt_keep_a: assert property (
    (uncond && stop_all && nrt_run && !cmd_ff[npt_pkg::CMD_NRT_STOP])
      |=> (nrt_run || nrt_exp))
    else $error("stop-all halted unconditional timer");
  nrt_busy_a: assert property (
    (nrt_exp && uncond && rx_busy_i && !nrt_go) |=>
      rx_gate_o == $past(rx_gate_o))
    else $error("unconditional expiry disturbed reception");
  nrt_stop_a: assert property (
    (cmd_ff[npt_pkg::CMD_NRT_STOP] && !nrt_go) |=>
      !nrt_run ##1 !nrt_exp)
    else $error("stopped timer still ran or expired");
  nrt_passive_a: assert property (
    (mode == npt_pkg::MODE_PAS_TGT && !nrt_run &&
     !cmd_ff[npt_pkg::CMD_NRT_GO]) |=> !nrt_run)
    else $error("passive target auto-started timer");
  pp_stop_a: assert property (
    (peer_field_on_i && !(active && tx_field_off_i)) |=>
      !pp_run ##1 !pp_exp)
    else $error("peer field did not stop wait timer");
  gp_flag_a: assert property (gp_exp |=> tirq_ff[npt_pkg::TIRQ_GP])
    else $error("general timer expiry not flagged");
  wu_refuse_a: assert property (
    (mode == npt_pkg::MODE_WAKEUP && !wu_run) |=> !rc_osc_en_o)
    else $error("wake start accepted in wake-up mode");
  flag_hold_a: assert property (
    (wt_ff && !clr_eirq) |=> wt_ff)
    else $error("wake flag lost without read");

endmodule // npt_top

// ---- npt_top_tb.sv ----
// Purpose: self-checking bench for the protocol timer unit
// Assumes: one-cycle Wishbone ack, small timer limits
// Notes:   reads are queued and checked by a monitor
module npt_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i  = 1'b0;
  logic        rst_i  = 1'b1;
  logic        wb_cyc = 1'b0;
  logic        wb_stb = 1'b0;
  logic        wb_we  = 1'b0;
  logic [7:2]  wb_adr = 6'h00;
  logic [31:0] wb_dat = 32'h0;
  logic [4:0]  ev     = 5'h00;
  logic        rx_busy = 1'b0;
  logic        osc_ok = 1'b1;
  logic [15:0] rnd    = 16'h2D29;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o, fc_tick, rc_tick, rx_gate_o, rc_osc_en_o, irq_o;
  logic [63:0] exp_q [$];
  int          err_total = 0;
  int          check_count = 0;
  int          cycles = 0;
  int          lim;
  logic [2:0]  t_mode [6] = '{3'h1, 3'h3, 3'h2, 3'h3, 3'h4, 3'h0};
  logic        t_peer [6] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
  int          t_ev   [6] = '{1, 1, 2, 2, 0, 1};
  logic [3:0]  t_exp  [6] = '{4'h5, 4'h5, 4'h1, 4'h0, 4'h0, 4'h0};

  always #12.5 clk_i = ~clk_i;

  npt_top i_npt_top (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF),
    .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .tx_end_i(ev[0]), .tx_field_off_i(ev[1]), .peer_field_on_i(ev[2]),
    .rx_start_i(ev[3]), .rx_end_i(ev[4]), .rx_busy_i(rx_busy),
    .fc_tick_i(fc_tick), .osc_ok_i(osc_ok), .rc_tick_i(rc_tick),
    .rx_gate_o(rx_gate_o), .rc_osc_en_o(rc_osc_en_o), .irq_o(irq_o));

  npt_fe_model i_npt_fe_model (
    .clk_i(clk_i), .rst_i(rst_i), .osc_ok_i(osc_ok),
    .rc_en_i(rc_osc_en_o), .fc_tick_o(fc_tick), .rc_tick_o(rc_tick));

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  function automatic logic [15:0] nxt_rnd(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  task automatic results();
    $display("errors %0d checks %0d", err_total, check_count);
    if (err_total == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_dat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    chk({31'h0, wb_ack_o}, 32'h1);
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rd(input logic [5:0] a, input logic [31:0] e,
                    input logic [31:0] m);
    exp_q.push_back({m, e & m});
    wb(1'b0, a, 32'h0);
  endtask

  task automatic cfg(input logic [2:0] m, input logic [1:0] g,
                     input logic p, input logic u, input logic s);
    wb(1'b1, npt_pkg::REG_CTRL, {24'h0, m, g, p, u, s});
  endtask

  task automatic cmd(input int b);
    wb(1'b1, npt_pkg::REG_CMD, 32'h1 << b);
  endtask

  task automatic pulse(input int b);
    ev[b] <= 1'b1;
    @(posedge clk_i);
    ev <= 5'h00;
    @(posedge clk_i);
  endtask

  task automatic wirq(input int n);
    int k;
    k = 0;
    while (irq_o !== 1'b1 && k < n) begin
      @(posedge clk_i);
      k++;
    end
    chk({31'h0, irq_o}, 32'h1);
  endtask

  // a restart must push expiry past the first start's deadline;
  // three steps keep the two windows apart despite the free prescaler
  task automatic restart(input int b, input logic [5:0] a,
                         input logic [31:0] f);
    wb(1'b1, a, 32'h3);
    cmd(b);
    repeat (100) @(posedge clk_i);
    cmd(b);
    repeat (100) @(posedge clk_i);
    chk({31'h0, irq_o}, 32'h0);
    wirq(140);
    rd(npt_pkg::REG_TIRQ, f, 32'h7);
    wb(1'b1, a, 32'h2);
  endtask

  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && wb_we === 1'b0 && exp_q.size() > 0) begin
      chk(wb_dat_o & exp_q[0][63:32], exp_q[0][31:0]);
      void'(exp_q.pop_front());
    end
  end

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 30000) begin
      err_total++;
      $display("MISMATCH t=%0t timeout", $time);
      results();
    end
  end

  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(npt_pkg::REG_CTRL, 32'h0, 32'hFF);
    rd(npt_pkg::REG_NRT, 32'hFFFF, 32'hFFFF);
    rd(npt_pkg::REG_STAT, 32'h30, 32'h3F);
    rd(6'h3F, 32'h0, 32'hFFFFFFFF);
    wb(1'b1, npt_pkg::REG_NRT, 32'h2);
    wb(1'b1, npt_pkg::REG_GP, 32'h2);
    wb(1'b1, npt_pkg::REG_PPON, 32'h2);
    wb(1'b1, npt_pkg::REG_WU, 32'h3);
    pulse(0);
    repeat (60) @(posedge clk_i);
    chk({31'h0, irq_o}, 32'h0);
    wirq(100);
    rd(npt_pkg::REG_TIRQ, 32'h1, 32'h7);
    chk({31'h0, rx_gate_o}, 32'h0);
    rd(npt_pkg::REG_TIRQ, 32'h0, 32'h7);
    pulse(0);
    pulse(3);
    repeat (200) @(posedge clk_i);
    rd(npt_pkg::REG_STAT, 32'h10, 32'h11);
    cfg(3'h0, 2'h0, 1'b0, 1'b0, 1'b1);
    cmd(npt_pkg::CMD_NRT_GO);
    repeat (4000) @(posedge clk_i);
    chk({31'h0, irq_o}, 32'h0);
    wirq(4300);
    rd(npt_pkg::REG_TIRQ, 32'h1, 32'h7);
    cfg(3'h0, 2'h0, 1'b0, 1'b0, 1'b0);
    restart(npt_pkg::CMD_NRT_GO, npt_pkg::REG_NRT, 32'h1);
    restart(npt_pkg::CMD_GP_GO, npt_pkg::REG_GP, 32'h2);
    for (int i = 0; i < 2; i++) begin
      cmd(npt_pkg::CMD_NRT_GO);
      cmd(i == 0 ? npt_pkg::CMD_NRT_STOP : npt_pkg::CMD_STOP_ALL);
      repeat (200) @(posedge clk_i);
      rd(npt_pkg::REG_TIRQ, 32'h0, 32'h7);
    end
    cfg(3'h0, 2'h0, 1'b0, 1'b1, 1'b0);
    for (int b = 1; b >= 0; b--) begin
      rx_busy <= b[0];
      pulse(0);
      pulse(3);
      cmd(npt_pkg::CMD_STOP_ALL);
      wirq(200);
      repeat (2) @(posedge clk_i);
      chk({31'h0, rx_gate_o}, {31'h0, b[0]});
      rd(npt_pkg::REG_TIRQ, 32'h1, 32'h7);
    end
    rx_busy <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      cfg(t_mode[i], 2'h0, t_peer[i], 1'b0, 1'b0);
      pulse(t_ev[i]);
      rd(npt_pkg::REG_STAT, {28'h0, t_exp[i]}, 32'hF);
      cmd(npt_pkg::CMD_STOP_ALL);
      rd(npt_pkg::REG_STAT, 32'h0, 32'hF);
    end
    cfg(3'h1, 2'h0, 1'b1, 1'b0, 1'b0);
    pulse(1);
    wirq(200);
    rd(npt_pkg::REG_TIRQ, 32'h4, 32'h7);
    pulse(1);
    repeat (10) @(posedge clk_i);
    pulse(2);
    cmd(npt_pkg::CMD_NRT_STOP);
    repeat (200) @(posedge clk_i);
    rd(npt_pkg::REG_TIRQ, 32'h0, 32'h7);
    wb(1'b1, npt_pkg::REG_PPON, 32'hFFFF);
    for (int t = 1; t <= 3; t++) begin
      rnd = nxt_rnd(rnd);
      lim = int'(rnd[1:0] % 2'h3) + 1;
      cfg(t == 3 ? 3'h1 : 3'h0, t[1:0], t == 3, 1'b0, 1'b0);
      wb(1'b1, npt_pkg::REG_GP, 32'(lim));
      pulse(t == 3 ? 1 : t + 2);
      repeat ((lim - 1) * 64) @(posedge clk_i);
      chk({31'h0, irq_o}, 32'h0);
      wirq(140);
      rd(npt_pkg::REG_TIRQ, 32'h2, 32'h7);
    end
    cmd(npt_pkg::CMD_STOP_ALL);
    cfg(3'h0, 2'h0, 1'b0, 1'b0, 1'b0);
    cmd(npt_pkg::CMD_WU_GO);
    repeat (2) @(posedge clk_i);
    chk({31'h0, rc_osc_en_o}, 32'h1);
    wirq(100);
    rd(npt_pkg::REG_EIRQ, 32'h1, 32'h1);
    cfg(3'h5, 2'h0, 1'b0, 1'b0, 1'b0);
    cmd(npt_pkg::CMD_WU_GO);
    repeat (2) @(posedge clk_i);
    chk({31'h0, rc_osc_en_o}, 32'h0);
    cfg(3'h4, 2'h0, 1'b0, 1'b0, 1'b0);
    pulse(2);
    repeat (2) @(posedge clk_i);
    chk({31'h0, rc_osc_en_o}, 32'h1);
    cmd(npt_pkg::CMD_STOP_ALL);
    repeat (2) @(posedge clk_i);
    chk({31'h0, rc_osc_en_o}, 32'h0);
    cfg(3'h0, 2'h0, 1'b0, 1'b0, 1'b0);
    wb(1'b1, npt_pkg::REG_GP, 32'h1);
    osc_ok <= 1'b0;
    cmd(npt_pkg::CMD_GP_GO);
    repeat (200) @(posedge clk_i);
    chk({31'h0, irq_o}, 32'h0);
    rd(npt_pkg::REG_STAT, 32'h2, 32'h22);
    osc_ok <= 1'b1;
    wirq(80);
    rd(npt_pkg::REG_TIRQ, 32'h2, 32'h7);
    results();
  end
endmodule // npt_top_tb
